// >>> logic/sigu_pkg.sv
// Package with register map, field positions and reset values for the unit
package sigu_pkg;
  localparam logic [7:0] SIGU_ADDR_IRQ_MODE = 8'h28;
  localparam logic [7:0] SIGU_ADDR_IRQ_MASK = 8'h29;
  localparam logic [7:0] SIGU_ADDR_IRQ_FLAGS = 8'h2a;
  localparam logic [7:0] SIGU_ADDR_CLIP_FLAGS = 8'h2b;
  localparam logic [7:0] SIGU_ADDR_PIN_DIR = 8'h2c;
  localparam logic [7:0] SIGU_ADDR_PIN_POL = 8'h2d;
  localparam logic [7:0] SIGU_ADDR_PIN_EDGE = 8'h2e;
  localparam logic [7:0] SIGU_ADDR_PIN_STATE = 8'h2f;
  localparam logic [7:0] SIGU_ADDR_PIN_MASK = 8'h30;
  // Main status bit positions
  localparam int SIGU_BIT_UNLOCK = 7;
  localparam int SIGU_BIT_LOCK = 6;
  localparam int SIGU_BIT_RISE = 5;
  localparam int SIGU_BIT_FALL = 4;
  localparam int SIGU_BIT_MUTE = 3;
  localparam int SIGU_BIT_CLIP = 2;
  localparam int SIGU_BIT_PIN = 1;
  // Mode register fields and pin mask width
  localparam int SIGU_MODE_LSB = 6;
  localparam int SIGU_CLIP_TYPE_BIT = 0;
  localparam int SIGU_PIN_MASK_W = 4;
  // Reset values
  localparam logic [7:0] SIGU_RST_ZERO = 8'h00;
  localparam logic [7:0] SIGU_RST_POL = 8'h7f;
  typedef enum logic [1:0] {
    SIGU_DRV_HIGH = 2'b00,
    SIGU_DRV_LOW = 2'b01,
    SIGU_DRV_OD_LOW = 2'b10,
    SIGU_DRV_RSVD = 2'b11
  } sigu_drive_t;
endpackage

// >>> logic/sigu_status_gpio.sv
// Status flags, channel clip flags and general-purpose pins of the unit
`timescale 1ns/1ns
module sigu_status_gpio
  import sigu_pkg::*;
#(
  parameter int NUM_CH = 6,
  parameter int NUM_PINS = 7
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic audio_input_error_i,
  input wire logic audio_frame_clock_lost_i,
  input wire logic audio_master_clock_lost_i,
  input wire logic clock_ratio_change_i,
  input wire logic rate_converter_locked_i,
  input wire logic ramp_rise_done_i,
  input wire logic ramp_fall_done_i,
  input wire logic mute_done_i,
  input wire logic [NUM_CH-1:0] channel_clip_i,
  input wire logic [NUM_PINS-1:0] pin_in_i,
  output logic [NUM_PINS-1:0] pin_out_o,
  output logic [NUM_PINS-1:0] pin_oe_o,
  output logic irq_out_o,
  output logic irq_oe_o
);

  if (NUM_CH < 1 || NUM_CH > 8 || NUM_PINS < SIGU_PIN_MASK_W ||
      NUM_PINS > 8) begin : g_bad_param
    $error("sigu_status_gpio: channel or pin count out of range");
  end

  // Sticky flag update; the event wins over a same-cycle clear
  function automatic logic [7:0] sticky(input logic [7:0] q,
                                        input logic [7:0] set,
                                        input logic [7:0] clr);
    sticky = set | (q & ~clr);
  endfunction

  logic [7:0] mode_q;
  logic [7:0] irq_mask_q;
  logic [7:0] flags_q;
  logic [NUM_CH-1:0] clip_q;
  logic [NUM_PINS-1:0] dir_q;
  logic [NUM_PINS-1:0] pol_q;
  logic [NUM_PINS-1:0] edge_q;
  logic [NUM_PINS-1:0] out_val_q;
  logic [NUM_PINS-1:0] edge_state_q;
  logic [SIGU_PIN_MASK_W-1:0] pin_mask_q;
  logic [NUM_PINS-1:0] sync1_q;
  logic [NUM_PINS-1:0] sync2_q;
  logic [NUM_PINS-1:0] active_prev_q;
  logic [7:0] rdata_q;
  logic irq_out_q;
  logic irq_oe_q;

  logic rd_flags;
  logic rd_clip;
  logic rd_pins;
  logic wr_mode;
  logic wr_mask;
  logic wr_dir;
  logic wr_pol;
  logic wr_edge;
  logic wr_state;
  logic wr_pmask;
  logic clip_edge_mode;
  logic unlock_evt;
  logic lock_evt;
  logic lock_prev_q;
  logic clip_summary;
  logic pin_summary;
  logic irq_active;
  logic [NUM_PINS-1:0] pin_active;
  logic [NUM_PINS-1:0] pin_state;
  logic [7:0] flags_view;
  logic [7:0] rd_mux;
  sigu_drive_t drive_mode;

  assign rd_flags = reg_rd_i && reg_addr_i == SIGU_ADDR_IRQ_FLAGS;
  assign rd_clip = reg_rd_i && reg_addr_i == SIGU_ADDR_CLIP_FLAGS;
  assign rd_pins = reg_rd_i && reg_addr_i == SIGU_ADDR_PIN_STATE;
  assign wr_mode = reg_wr_i && reg_addr_i == SIGU_ADDR_IRQ_MODE;
  assign wr_mask = reg_wr_i && reg_addr_i == SIGU_ADDR_IRQ_MASK;
  assign wr_dir = reg_wr_i && reg_addr_i == SIGU_ADDR_PIN_DIR;
  assign wr_pol = reg_wr_i && reg_addr_i == SIGU_ADDR_PIN_POL;
  assign wr_edge = reg_wr_i && reg_addr_i == SIGU_ADDR_PIN_EDGE;
  assign wr_state = reg_wr_i && reg_addr_i == SIGU_ADDR_PIN_STATE;
  assign wr_pmask = reg_wr_i && reg_addr_i == SIGU_ADDR_PIN_MASK;

  assign clip_edge_mode = mode_q[SIGU_CLIP_TYPE_BIT];
  assign drive_mode = sigu_drive_t'(mode_q[SIGU_MODE_LSB +: 2]);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= SIGU_RST_ZERO;
      irq_mask_q <= SIGU_RST_ZERO;
    end else begin
      if (wr_mode) begin
        mode_q <= reg_wdata_i;
      end
      if (wr_mask) begin
        irq_mask_q <= reg_wdata_i;
      end
    end
  end

  // clock faults count as lock loss
  assign unlock_evt = audio_input_error_i | audio_frame_clock_lost_i |
                      audio_master_clock_lost_i | clock_ratio_change_i |
                      (lock_prev_q & ~rate_converter_locked_i);
  assign lock_evt = rate_converter_locked_i & ~lock_prev_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_prev_q <= 1'b0;
    end else begin
      lock_prev_q <= rate_converter_locked_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_q <= SIGU_RST_ZERO;
    end else begin
      flags_q <= sticky(flags_q,
                        {unlock_evt, lock_evt & ~unlock_evt,
                         ramp_rise_done_i, ramp_fall_done_i, mute_done_i,
                         3'b000},
                        {lock_evt | rd_flags, unlock_evt | rd_flags,
                         {3{rd_flags}}, 3'b111});
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clip_q <= '0;
    end else if (rd_clip) begin
      // both modes alike: idle channels clear, still-clipping channels stay set
      clip_q <= channel_clip_i |
                (clip_edge_mode ? '0 : (clip_q & channel_clip_i));
    end else begin
      clip_q <= clip_q | channel_clip_i;
    end
  end

  assign clip_summary = |clip_q;

  // Pins arrive from outside; two stages before any use
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_in_i;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dir_q <= SIGU_RST_ZERO[NUM_PINS-1:0];
      pol_q <= SIGU_RST_POL[NUM_PINS-1:0];
      edge_q <= SIGU_RST_ZERO[NUM_PINS-1:0];
      pin_mask_q <= SIGU_RST_ZERO[SIGU_PIN_MASK_W-1:0];
    end else begin
      if (wr_dir) begin
        dir_q <= reg_wdata_i[NUM_PINS-1:0];
      end
      if (wr_pol) begin
        pol_q <= reg_wdata_i[NUM_PINS-1:0];
      end
      if (wr_edge) begin
        edge_q <= reg_wdata_i[NUM_PINS-1:0];
      end
      if (wr_pmask) begin
        pin_mask_q <= reg_wdata_i[SIGU_PIN_MASK_W-1:0];
      end
    end
  end

  assign pin_active = ~dir_q & ~(sync2_q ^ pol_q);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_prev_q <= '0;
    end else begin
      active_prev_q <= pin_active;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      edge_state_q <= '0;
    end else begin
      edge_state_q <= (pin_active & ~active_prev_q) |
                      (edge_state_q & {NUM_PINS{~rd_pins}});
    end
  end

  // output level written through pin state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_val_q <= '0;
    end else if (wr_state) begin
      out_val_q <= reg_wdata_i[NUM_PINS-1:0];
    end
  end

  assign pin_state = (dir_q & out_val_q) | (~dir_q &
                     ((edge_q & edge_state_q) | (~edge_q & pin_active)));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_out_o <= '0;
      pin_oe_o <= '0;
    end else begin
      pin_out_o <= out_val_q & ~pol_q;
      pin_oe_o <= dir_q & (~pol_q | ~out_val_q);
    end
  end

  // only masked-in lower pins reach the summary
  assign pin_summary = |(pin_state[SIGU_PIN_MASK_W-1:0] & pin_mask_q &
                         ~dir_q[SIGU_PIN_MASK_W-1:0]);

  always_comb begin
    flags_view = flags_q;
    flags_view[SIGU_BIT_CLIP] = clip_summary;
    flags_view[SIGU_BIT_PIN] = pin_summary;
  end

  // aligned main mask; pin summary has its own mask
  assign irq_active = |(flags_view & (irq_mask_q |
                        (8'h01 << SIGU_BIT_PIN)) & 8'hfe);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_out_q <= 1'b0;
      irq_oe_q <= 1'b0;
    end else begin
      case (drive_mode)
        SIGU_DRV_HIGH: begin
          irq_out_q <= irq_active;
          irq_oe_q <= 1'b1;
        end
        SIGU_DRV_LOW: begin
          irq_out_q <= ~irq_active;
          irq_oe_q <= 1'b1;
        end
        SIGU_DRV_OD_LOW: begin
          irq_out_q <= 1'b0;
          irq_oe_q <= irq_active;
        end
        default: begin
          irq_out_q <= 1'b0;
          irq_oe_q <= 1'b0;
        end
      endcase
    end
  end

  assign irq_out_o = irq_out_q;
  assign irq_oe_o = irq_oe_q;

  always_comb begin
    case (reg_addr_i)
      SIGU_ADDR_IRQ_MODE: rd_mux = mode_q & 8'hc1;
      SIGU_ADDR_IRQ_MASK: rd_mux = irq_mask_q;
      SIGU_ADDR_IRQ_FLAGS: rd_mux = flags_view;
      SIGU_ADDR_CLIP_FLAGS: rd_mux = 8'(clip_q);
      SIGU_ADDR_PIN_DIR: rd_mux = 8'(dir_q);
      SIGU_ADDR_PIN_POL: rd_mux = 8'(pol_q);
      SIGU_ADDR_PIN_EDGE: rd_mux = 8'(edge_q);
      SIGU_ADDR_PIN_STATE: rd_mux = 8'(pin_state);
      SIGU_ADDR_PIN_MASK: rd_mux = {4'h0, pin_mask_q};
      default: rd_mux = SIGU_RST_ZERO;
    endcase
  end

  // Read data captured at the same edge that performs read-clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= SIGU_RST_ZERO;
    end else if (reg_rd_i) begin
      rdata_q <= rd_mux;
    end
  end

  assign reg_rdata_o = rdata_q;

  property p_unlock_set;
    @(posedge clk_i) disable iff (!rst_n_i)
    audio_frame_clock_lost_i |=> flags_q[SIGU_BIT_UNLOCK];
  endproperty
  a_unlock_set: assert property (p_unlock_set)
    else $error("unlock flag not set by frame clock loss");

  property p_lock_clears_unlock;
    @(posedge clk_i) disable iff (!rst_n_i)
    (lock_evt && !unlock_evt) |=> !flags_q[SIGU_BIT_UNLOCK];
  endproperty
  a_lock_clears_unlock: assert property (p_lock_clears_unlock)
    else $error("lock event left unlock flag set");

  property p_unlock_clears_lock;
    @(posedge clk_i) disable iff (!rst_n_i)
    unlock_evt |=> !flags_q[SIGU_BIT_LOCK];
  endproperty
  a_unlock_clears_lock: assert property (p_unlock_clears_lock)
    else $error("unlock event left lock flag set");

  property p_read_clears;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_flags && !ramp_rise_done_i) |=> !flags_q[SIGU_BIT_RISE];
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("ramp flag survived status read");

  property p_set_wins;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_flags && mute_done_i) |=> flags_q[SIGU_BIT_MUTE];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("mute event lost against read clear");

  property p_clip_sum;
    @(posedge clk_i) disable iff (!rst_n_i)
    channel_clip_i[0] |=> flags_view[SIGU_BIT_CLIP] ##1
      (flags_view[SIGU_BIT_CLIP] || $past(rd_clip));
  endproperty
  a_clip_sum: assert property (p_clip_sum)
    else $error("clip summary did not follow channel bit");

  property p_clip_level_keep;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_clip && !clip_edge_mode && clip_q[0] && channel_clip_i[0])
      |=> clip_q[0];
  endproperty
  a_clip_level_keep: assert property (p_clip_level_keep)
    else $error("level clip bit cleared while active");

  property p_clip_edge_clear;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_clip && clip_edge_mode) |=> clip_q == $past(channel_clip_i);
  endproperty
  a_clip_edge_clear: assert property (p_clip_edge_clear)
    else $error("edge clip bit not cleared by read");

  property p_main_read_keeps_pins;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_flags && !rd_pins) |=> (edge_state_q & $past(edge_state_q)) ==
      $past(edge_state_q);
  endproperty
  a_main_read_keeps_pins: assert property (p_main_read_keeps_pins)
    else $error("main status read disturbed pin state");

  property p_push_pull;
    @(posedge clk_i) disable iff (!rst_n_i)
    |(dir_q & ~pol_q) |=> ((~pin_oe_o | (pin_out_o ^ $past(out_val_q))) &
      $past(dir_q) & ~$past(pol_q)) == '0;
  endproperty
  a_push_pull: assert property (p_push_pull)
    else $error("push-pull pin not driven with its value");

  property p_irq_high_mode;
    @(posedge clk_i) disable iff (!rst_n_i)
    (drive_mode == SIGU_DRV_HIGH && irq_active) |=> irq_out_o && irq_oe_o;
  endproperty
  a_irq_high_mode: assert property (p_irq_high_mode)
    else $error("interrupt pin not asserted high");

  property p_irq_od_mode;
    @(posedge clk_i) disable iff (!rst_n_i)
    (drive_mode == SIGU_DRV_OD_LOW) |=> !irq_out_o &&
      irq_oe_o == $past(irq_active);
  endproperty
  a_irq_od_mode: assert property (p_irq_od_mode)
    else $error("open-drain interrupt drive wrong");

endmodule // sigu_status_gpio

// >>> tb/status_interrupt_gpio_unit_tb.sv
// Register-level testbench for the status, clip and pin unit
`timescale 1ns/1ns
`define CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("mismatch at %0t got %h exp %h", $time, got, exp); \
  end \
end
module status_interrupt_gpio_unit_tb;
  import sigu_pkg::*;
  logic clk_i;
  logic rst_n_i;
  logic [7:0] reg_addr_i;
  logic reg_wr_i;
  logic [7:0] reg_wdata_i;
  logic reg_rd_i;
  logic [7:0] reg_rdata_o;
  logic [6:0] ev;
  logic lk;
  logic [5:0] cl;
  logic [6:0] pin_ext;
  logic [6:0] pin_in;
  logic [6:0] pin_out_o;
  logic [6:0] pin_oe_o;
  logic irq_out_o;
  logic irq_oe_o;
  int err_total;
  int check_count;
  int cyc_count;
  logic [7:0] ra [9];
  logic [7:0] re [9];
  logic [7:0] ev_bit [7];
  logic [1:0] drv_exp [4];

  // Undriven pins read the outside level, driven pins their own value
  assign pin_in = (pin_out_o & pin_oe_o) | (pin_ext & ~pin_oe_o);

  sigu_status_gpio dut_u (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .audio_input_error_i(ev[0]),
    .audio_frame_clock_lost_i(ev[1]),
    .audio_master_clock_lost_i(ev[2]),
    .clock_ratio_change_i(ev[3]),
    .rate_converter_locked_i(lk),
    .ramp_rise_done_i(ev[4]),
    .ramp_fall_done_i(ev[5]),
    .mute_done_i(ev[6]),
    .channel_clip_i(cl),
    .pin_in_i(pin_in),
    .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o),
    .irq_out_o(irq_out_o),
    .irq_oe_o(irq_oe_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk_i) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 3000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    `CHK(reg_rdata_o, e)
  endtask

  task automatic pulse(input int k);
    @(posedge clk_i);
    ev <= 7'(1 << k);
    @(posedge clk_i);
    ev <= 7'h00;
  endtask

  initial begin
    ra = '{8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h30, 8'h31};
    re = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h7f, 8'h00, 8'h00, 8'h00};
    ev_bit = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h20, 8'h10, 8'h08};
    drv_exp = '{2'b11, 2'b01, 2'b01, 2'b00};
    err_total = 0;
    check_count = 0;
    cyc_count = 0;
    rst_n_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_wdata_i = 8'h00;
    reg_rd_i = 1'b0;
    ev = 7'h00;
    lk = 1'b0;
    cl = 6'h00;
    pin_ext = 7'h00;
    @(negedge clk_i);
    `CHK({irq_oe_o, pin_oe_o}, 8'h00)
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 9; i++) rdc(ra[i], re[i]);
    for (int k = 0; k < 7; k++) begin
      pulse(k);
      rdc(SIGU_ADDR_IRQ_FLAGS, ev_bit[k]);
      rdc(SIGU_ADDR_IRQ_FLAGS, 8'h00);
    end
    // event in the read cycle survives the clear
    @(posedge clk_i);
    ev <= 7'h40;
    reg_addr_i <= SIGU_ADDR_IRQ_FLAGS;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    ev <= 7'h00;
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    `CHK(reg_rdata_o, 8'h00)
    rdc(SIGU_ADDR_IRQ_FLAGS, 8'h08);
    @(posedge clk_i);
    lk <= 1'b1;
    cyc(2);
    rdc(SIGU_ADDR_IRQ_FLAGS, 8'h40);
    @(posedge clk_i);
    lk <= 1'b0;
    cyc(2);
    pulse(0);
    rdc(SIGU_ADDR_IRQ_FLAGS, 8'h80);
    @(posedge clk_i);
    lk <= 1'b1;
    cyc(2);
    pulse(2);
    rdc(SIGU_ADDR_IRQ_FLAGS, 8'h80);
    @(posedge clk_i);
    lk <= 1'b0;
    cyc(2);
    @(posedge clk_i);
    lk <= 1'b1;
    cyc(2);
    rdc(SIGU_ADDR_IRQ_FLAGS, 8'h40);
    pulse(4);
    cyc(3);
    @(negedge clk_i);
    `CHK({irq_out_o, irq_oe_o}, 2'b01)
    wr(SIGU_ADDR_IRQ_MASK, 8'h08);
    pulse(6);
    for (int m = 0; m < 4; m++) begin
      wr(SIGU_ADDR_IRQ_MODE, 8'(m << SIGU_MODE_LSB));
      cyc(2);
      @(negedge clk_i);
      `CHK({irq_out_o, irq_oe_o}, drv_exp[m])
    end
    wr(SIGU_ADDR_IRQ_MODE, 8'h80);
    rdc(SIGU_ADDR_IRQ_FLAGS, 8'h28);
    cyc(2);
    @(negedge clk_i);
    `CHK({irq_out_o, irq_oe_o}, 2'b00)
    wr(SIGU_ADDR_IRQ_MODE, 8'h00);
    wr(SIGU_ADDR_IRQ_MASK, 8'h00);
    // clip flags, level then edge type
    @(posedge clk_i);
    cl <= 6'h01;
    cyc(2);
    rdc(SIGU_ADDR_CLIP_FLAGS, 8'h01);
    rdc(SIGU_ADDR_CLIP_FLAGS, 8'h01);
    rdc(SIGU_ADDR_IRQ_FLAGS, 8'h04);
    @(posedge clk_i);
    cl <= 6'h00;
    rdc(SIGU_ADDR_CLIP_FLAGS, 8'h01);
    rdc(SIGU_ADDR_CLIP_FLAGS, 8'h00);
    wr(SIGU_ADDR_IRQ_MODE, 8'h01);
    @(posedge clk_i);
    cl <= 6'h24;
    @(posedge clk_i);
    cl <= 6'h00;
    rdc(SIGU_ADDR_IRQ_FLAGS, 8'h04);
    rdc(SIGU_ADDR_CLIP_FLAGS, 8'h24);
    rdc(SIGU_ADDR_CLIP_FLAGS, 8'h00);
    rdc(SIGU_ADDR_IRQ_FLAGS, 8'h00);
    wr(SIGU_ADDR_PIN_EDGE, 8'h04);
    for (int u = 0; u < 2; u++) begin
      wr(SIGU_ADDR_PIN_MASK, 8'(u << 2));
      pin_ext <= 7'h04;
      cyc(4);
      pin_ext <= 7'h00;
      cyc(4);
      rdc(SIGU_ADDR_IRQ_FLAGS, 8'(u << 1));
      rdc(SIGU_ADDR_IRQ_FLAGS, 8'(u << 1));
      rdc(SIGU_ADDR_PIN_STATE, 8'h04);
      rdc(SIGU_ADDR_PIN_STATE, 8'h00);
      rdc(SIGU_ADDR_IRQ_FLAGS, 8'h00);
    end
    @(posedge clk_i);
    pin_ext <= 7'h01;
    cyc(4);
    rdc(SIGU_ADDR_PIN_STATE, 8'h01);
    rdc(SIGU_ADDR_PIN_STATE, 8'h01);
    rdc(SIGU_ADDR_IRQ_FLAGS, 8'h00);
    wr(SIGU_ADDR_PIN_MASK, 8'hff);
    rdc(SIGU_ADDR_PIN_MASK, 8'h0f);
    rdc(SIGU_ADDR_IRQ_FLAGS, 8'h02);
    @(negedge clk_i);
    `CHK({irq_out_o, irq_oe_o}, 2'b11)
    @(posedge clk_i);
    pin_ext <= 7'h02;
    wr(SIGU_ADDR_PIN_POL, 8'h7d);
    cyc(4);
    rdc(SIGU_ADDR_PIN_STATE, 8'h00);
    @(posedge clk_i);
    pin_ext <= 7'h00;
    cyc(4);
    rdc(SIGU_ADDR_PIN_STATE, 8'h02);
    rdc(SIGU_ADDR_IRQ_FLAGS, 8'h02);
    // push-pull pin 5, open-drain pin 6
    wr(SIGU_ADDR_PIN_MASK, 8'h00);
    pin_ext <= 7'h01;
    wr(SIGU_ADDR_PIN_POL, 8'h5f);
    wr(SIGU_ADDR_PIN_DIR, 8'h60);
    rdc(SIGU_ADDR_PIN_DIR, 8'h60);
    wr(SIGU_ADDR_PIN_STATE, 8'h60);
    cyc(2);
    @(negedge clk_i);
    `CHK({pin_out_o & 7'h60, pin_oe_o}, {7'h20, 7'h20})
    rdc(SIGU_ADDR_PIN_STATE, 8'h61);
    wr(SIGU_ADDR_PIN_STATE, 8'h00);
    cyc(2);
    @(negedge clk_i);
    `CHK({pin_out_o & 7'h60, pin_oe_o}, {7'h00, 7'h60})
    rdc(SIGU_ADDR_PIN_STATE, 8'h01);
    finish_test();
  end
endmodule // status_interrupt_gpio_unit_tb
